// file: ptc_params.svh
// Constants for the panel timing configuration register bank
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define PTC_CLK_PERIOD_PS   5000
`define PTC_RST_MIN_NS      1000
`define PTC_RST_FILT_CYC    ((`PTC_RST_MIN_NS * 1000 + `PTC_CLK_PERIOD_PS - 1) / `PTC_CLK_PERIOD_PS)
`define PTC_ADDR_SYS        6'h00
`define PTC_ADDR_FIRST      6'h04
`define PTC_ADDR_LAST       6'h12
`define PTC_ADDR_WIDE       6'h20
`define PTC_SLOT_WIDE       4'hF
`define PTC_SYS_RD          8'h01
`define PTC_OFS_601         9'h080
`define PTC_OFS_656         9'h088
`define PTC_DATA_DELAY_CODE_DEF_601    8'h46
`define PTC_DATA_DELAY_CODE_DEF_656    8'h46
`define PTC_DATA_DELAY_CODE_DEF_RGB    8'h46
`define PTC_GATE_DELAY_CODE_DEF_601    8'h0D
`define PTC_GATE_DELAY_CODE_DEF_656    8'h0D
`define PTC_GATE_DELAY_CODE_DEF_RGB    8'h0D
`define PTC_RST_04  8'h46
`define PTC_RST_05  8'h0D
`define PTC_RST_07  8'h00
`define PTC_RST_08  8'h08
`define PTC_RST_09  8'h40
`define PTC_RST_0A  8'h88
`define PTC_RST_0B  8'h88
`define PTC_RST_0C  8'h20
`define PTC_RST_0D  8'h20
`define PTC_RST_0E  8'h10
`define PTC_RST_0F  8'hA4
`define PTC_RST_10  8'h04
`define PTC_RST_11  8'h24
`define PTC_RST_12  8'h24
`define PTC_RST_20  8'h00
`define PTC_MSK_05  8'h7F
`define PTC_MSK_07  8'hFD
`define PTC_MSK_08  8'h1F
`define PTC_MSK_09  8'h7F
`define PTC_MSK_0B  8'hCC
`define PTC_MSK_0C  8'h3F
`define PTC_MSK_0E  8'h7F
`define PTC_MSK_10  8'h17
`define PTC_MSK_11  8'h3F
`define PTC_MSK_20  8'h03
`define PTC_SPI_BITS        5'h10
`define PTC_SPI_TA          5'h08
`define PTC_SPI_RW          5'h07
`define PTC_CON_UNITY       4'h8
`define PTC_BRI_ZERO        8'h80
`define PTC_HUE_ZERO        7'h28
`define PTC_HUE_STEP        7'h05
`define PTC_SBRI_ZERO       6'h20
`define PTC_SCON_BASE       4'h6
`define PTC_DC_BASE_MV      12'h3E8
`define PTC_DC_STEP_MV      12'h014
`define PTC_AC_BASE         6'h2E
`define PTC_VGH_BASE        4'hC
`define PTC_VGL_BASE        4'h7
`define PTC_GAM_TOP_MV      8'h58
`define PTC_GAM_STEP_MV     8'h16
`define PTC_FA_EVEN_LATE    2'h1
`define PTC_FA_ODD_LATE     2'h2
`endif

// file: ptc_pkg.sv
// Types shared by the panel timing configuration register bank
package ptc_pkg;
  typedef struct packed {
    logic pclk;
    logic hsync_n;
    logic vsync_n;
  } ptc_video_t;
  typedef struct packed {
    logic spen_n;
    logic spck;
    logic sda;
  } ptc_serial_t;
  typedef struct packed {
    logic [8:0]      first_data_dly;
    logic [7:0]      gate_dly_lines;
    logic [1:0]      source_drive_mode;
    logic            pal_active;
    logic            pal_288_lines;
    logic            luma_average;
    logic [4:0]      contrast_x8;
    logic [7:0]      brightness_ofs;
    logic [6:0]      hue_deg;
    logic [3:0]      saturation_x8;
    logic [3:0]      red_contrast_x8;
    logic [3:0]      blue_contrast_x8;
    logic [5:0]      red_brightness_ofs;
    logic [5:0]      blue_brightness_ofs;
    logic [5:0]      common_dc_code;
    logic [11:0]     common_dc_mv;
    logic [5:0]      common_ac_x100mv;
    logic            levels_valid;
    logic [3:0]      gate_high_v;
    logic [3:0]      gate_low_neg_v;
    logic            gamma_active;
    logic [4:0][7:0] gamma_ofs_mv;
    logic [1:0]      display_width_mode;
  } ptc_cfg_t;
endpackage

// file: ptc_regs.sv
// Panel timing configuration register bank with serial access and timing counters
`timescale 1ns/1ps
`default_nettype none
`include "ptc_params.svh"
module ptc_regs #(
  parameter int RST_FILT_CYC = `PTC_RST_FILT_CYC
) (
  input  wire logic              mclk_i,
  input  wire logic              arst_n_i,
  input  wire logic              reset_input_n_i,
  input  wire ptc_pkg::ptc_serial_t ser_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire ptc_pkg::ptc_video_t  vid_i,
  input  wire logic [3:0]        input_format_i,
  input  wire logic              pin_control_bit_i,
  input  wire logic              gamma_source_select_i,
  input  wire logic              voltage_switch_bit_i,
  input  wire logic [5:0]        otp_dc_code_i,
  output logic                   first_data_o,
  output logic                   gate_start_o,
  output logic                   core_rst_o,
  output ptc_pkg::ptc_cfg_t      cfg_o
);
  import ptc_pkg::*;

  logic [7:0]  mem [0:15];
  logic [2:0]  ser_sync [0:2];
  logic [2:0]  vid_sync [0:2];
  logic [1:0]  rst_sync_reg;
  logic [15:0] rst_cnt_reg;
  logic        filt_rst_reg;
  logic        soft_rst_reg;
  logic        clr;
  logic [4:0]  bit_cnt_reg;
  logic [14:0] shift_reg;
  logic        rd_reg;
  logic [7:0]  tx_reg;
  logic        wr_en_reg;
  logic [5:0]  wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic [3:0]  sel_prev_reg;
  logic [8:0]  px_cnt_reg;
  logic        px_run_reg;
  logic [7:0]  ln_cnt_reg;
  logic        ln_run_reg;
  logic        odd_frame_reg;
  logic        spen_n, spck_rise, spck_fall, sda_in;
  logic        pclk_rise, hs_fall, vs_fall;
  logic        is601, is656, is_yuv, is_de;
  logic [7:0]  data_delay_code_eff, gate_delay_code_eff;
  logic [8:0]  ths;
  logic [7:0]  tvs;
  logic        adv;
  ptc_cfg_t    cfg_next;

  function automatic logic [3:0] slot_f(input logic [5:0] a);
    slot_f = (a == `PTC_ADDR_WIDE) ? `PTC_SLOT_WIDE : 4'(a - `PTC_ADDR_FIRST);
  endfunction

  function automatic logic mapped_f(input logic [5:0] a);
    mapped_f = (a >= `PTC_ADDR_FIRST && a <= `PTC_ADDR_LAST) || a == `PTC_ADDR_WIDE;
  endfunction

  function automatic logic [7:0] rstv_f(input logic [3:0] s);
    case (s)
      4'h0:    rstv_f = `PTC_RST_04;
      4'h1:    rstv_f = `PTC_RST_05;
      4'h3:    rstv_f = `PTC_RST_07;
      4'h4:    rstv_f = `PTC_RST_08;
      4'h5:    rstv_f = `PTC_RST_09;
      4'h6:    rstv_f = `PTC_RST_0A;
      4'h7:    rstv_f = `PTC_RST_0B;
      4'h8:    rstv_f = `PTC_RST_0C;
      4'h9:    rstv_f = `PTC_RST_0D;
      4'hA:    rstv_f = `PTC_RST_0E;
      4'hB:    rstv_f = `PTC_RST_0F;
      4'hC:    rstv_f = `PTC_RST_10;
      4'hD:    rstv_f = `PTC_RST_11;
      4'hE:    rstv_f = `PTC_RST_12;
      4'hF:    rstv_f = `PTC_RST_20;
      default: rstv_f = 8'h00;
    endcase
  endfunction

  // Reserved slot and reserved bits stay zero
  function automatic logic [7:0] mask_f(input logic [3:0] s);
    case (s)
      4'h0, 4'h6, 4'hB: mask_f = 8'hFF;
      4'h1:             mask_f = `PTC_MSK_05;
      4'h3:             mask_f = `PTC_MSK_07;
      4'h4:             mask_f = `PTC_MSK_08;
      4'h5:             mask_f = `PTC_MSK_09;
      4'h7:             mask_f = `PTC_MSK_0B;
      4'h8, 4'h9:       mask_f = `PTC_MSK_0C;
      4'hA:             mask_f = `PTC_MSK_0E;
      4'hC:             mask_f = `PTC_MSK_10;
      4'hD, 4'hE:       mask_f = `PTC_MSK_11;
      4'hF:             mask_f = `PTC_MSK_20;
      default:          mask_f = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rdata_f(input logic [5:0] a, input logic [7:0] v);
    if (a == `PTC_ADDR_SYS)
      rdata_f = `PTC_SYS_RD;
    else if (mapped_f(a))
      rdata_f = v;
    else
      rdata_f = 8'h00;
  endfunction

  function automatic logic [7:0] def_data_delay_code_f(input logic [3:0] s);
    def_data_delay_code_f = s[3] ? `PTC_DATA_DELAY_CODE_DEF_RGB : (s[2] ? `PTC_DATA_DELAY_CODE_DEF_656 : `PTC_DATA_DELAY_CODE_DEF_601);
  endfunction

  function automatic logic [7:0] def_gate_delay_code_f(input logic [3:0] s);
    def_gate_delay_code_f = s[3] ? `PTC_GATE_DELAY_CODE_DEF_RGB : (s[2] ? `PTC_GATE_DELAY_CODE_DEF_656 : `PTC_GATE_DELAY_CODE_DEF_601);
  endfunction

  // Pin synchronisers; only stage 1 and 2 are read by logic
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < 3; i++)
      begin
        ser_sync[i] <= 3'h7;
        vid_sync[i] <= 3'h3;
      end
    end
    else
    begin
      ser_sync[0] <= ser_i;
      vid_sync[0] <= vid_i;
      for (int i = 1; i < 3; i++)
      begin
        ser_sync[i] <= ser_sync[i-1];
        vid_sync[i] <= vid_sync[i-1];
      end
    end
  end

  assign spen_n    = ser_sync[1][2];
  assign spck_rise = ser_sync[1][1] & ~ser_sync[2][1];
  assign spck_fall = ~ser_sync[1][1] & ser_sync[2][1];
  assign sda_in    = ser_sync[1][0];
  assign pclk_rise = vid_sync[1][2] & ~vid_sync[2][2];
  assign hs_fall   = ~vid_sync[1][1] & vid_sync[2][1];
  assign vs_fall   = ~vid_sync[1][0] & vid_sync[2][0];

  // Reset pin must stay low the full width; shorter pulses are glitches
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_sync_reg <= 2'h3;
      rst_cnt_reg  <= 16'h0000;
      filt_rst_reg <= 1'b1;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], reset_input_n_i};
      if (rst_sync_reg[1])
        rst_cnt_reg <= 16'h0000;
      else if (rst_cnt_reg != 16'(RST_FILT_CYC))
        rst_cnt_reg <= rst_cnt_reg + 16'h0001;
      filt_rst_reg <= !rst_sync_reg[1] && rst_cnt_reg == 16'(RST_FILT_CYC);
    end
  end

  // Soft reset pulse; the bit itself always reads back as one
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= wr_en_reg && wr_addr_reg == `PTC_ADDR_SYS && !wr_data_reg[0];
  end

  assign clr        = soft_rst_reg | filt_rst_reg;
  assign core_rst_o = clr;

  // Serial frame: six address bits, read flag, turnaround, eight data bits
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg   <= 15'h0000;
      rd_reg      <= 1'b0;
      tx_reg      <= 8'h00;
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 6'h00;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      wr_en_reg <= 1'b0;
      if (spen_n || clr)
      begin
        bit_cnt_reg <= 5'h00;
        rd_reg      <= 1'b0;
      end
      else if (spck_rise && bit_cnt_reg != `PTC_SPI_BITS)
      begin
        shift_reg   <= {shift_reg[13:0], sda_in};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == 5'(`PTC_SPI_RW - 5'h01))
          rd_reg <= sda_in;
        if (bit_cnt_reg == 5'(`PTC_SPI_TA - 5'h01))
          tx_reg <= rdata_f(shift_reg[6:1], mem[slot_f(shift_reg[6:1])]);
        if (bit_cnt_reg == 5'(`PTC_SPI_BITS - 5'h01) && !rd_reg)
        begin
          wr_en_reg   <= 1'b1;
          wr_addr_reg <= shift_reg[14:9];
          wr_data_reg <= {shift_reg[6:0], sda_in};
        end
      end
      else if (spck_fall && bit_cnt_reg > `PTC_SPI_TA)
        tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  assign sda_o    = tx_reg[7];
  assign sda_oe_o = rd_reg && !spen_n && bit_cnt_reg >= `PTC_SPI_TA
                    && bit_cnt_reg != `PTC_SPI_BITS;

  // Register storage; a serial write wins over a format reload in the same cycle
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= rstv_f(4'(i));
      sel_prev_reg <= 4'h0;
    end
    else if (clr)
    begin
      for (int i = 0; i < 16; i++)
        mem[i] <= rstv_f(4'(i));
      sel_prev_reg <= input_format_i;
    end
    else
    begin
      sel_prev_reg <= input_format_i;
      if (input_format_i != sel_prev_reg)
      begin
        mem[0] <= def_data_delay_code_f(input_format_i);
        mem[1] <= def_gate_delay_code_f(input_format_i);
      end
      if (wr_en_reg && mapped_f(wr_addr_reg))
        mem[slot_f(wr_addr_reg)] <= wr_data_reg & mask_f(slot_f(wr_addr_reg));
    end
  end

  assign is601  = input_format_i[3:2] == 2'b00;
  assign is656  = input_format_i[3:1] == 3'b010;
  assign is_yuv = is601 | is656;
  assign is_de  = input_format_i[3] & input_format_i[0];

  // DE mode without pin control falls back to format defaults
  assign data_delay_code_eff = (is_de && !pin_control_bit_i) ? def_data_delay_code_f(input_format_i) : mem[0];
  assign gate_delay_code_eff = (is_de && !pin_control_bit_i) ? def_gate_delay_code_f(input_format_i) : mem[1];

  // Mode offset added to data delay
  assign ths = is601 ? 9'(data_delay_code_eff) + `PTC_OFS_601 :
               is656 ? 9'(data_delay_code_eff) + `PTC_OFS_656 : 9'(data_delay_code_eff);
  // One line late on the selected parity, 601/656 only
  assign adv = is_yuv && ((mem[3][7:6] == `PTC_FA_EVEN_LATE && !odd_frame_reg) ||
                          (mem[3][7:6] == `PTC_FA_ODD_LATE && odd_frame_reg));
  assign tvs = {1'b0, gate_delay_code_eff[6:0]} + {7'h00, adv};

  // First data position counted in pixel clocks after sync
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      px_cnt_reg   <= 9'h000;
      px_run_reg   <= 1'b0;
      first_data_o <= 1'b0;
    end
    else
    begin
      first_data_o <= 1'b0;
      if (clr)
        px_run_reg <= 1'b0;
      else if (hs_fall)
      begin
        px_cnt_reg <= 9'h000;
        px_run_reg <= 1'b1;
      end
      else if (px_run_reg && px_cnt_reg == ths)
      begin
        first_data_o <= 1'b1;
        px_run_reg   <= 1'b0;
      end
      else if (px_run_reg && pclk_rise)
        px_cnt_reg <= px_cnt_reg + 9'h001;
    end
  end

  // Gate start counted in line syncs after frame sync
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ln_cnt_reg    <= 8'h00;
      ln_run_reg    <= 1'b0;
      odd_frame_reg <= 1'b0;
      gate_start_o  <= 1'b0;
    end
    else
    begin
      gate_start_o <= 1'b0;
      if (clr)
      begin
        ln_run_reg    <= 1'b0;
        odd_frame_reg <= 1'b0;
      end
      else if (vs_fall)
      begin
        ln_cnt_reg    <= 8'h00;
        ln_run_reg    <= 1'b1;
        odd_frame_reg <= !odd_frame_reg;
      end
      else if (ln_run_reg && hs_fall)
      begin
        if (ln_cnt_reg == tvs)
        begin
          gate_start_o <= 1'b1;
          ln_run_reg   <= 1'b0;
        end
        else
          ln_cnt_reg <= ln_cnt_reg + 8'h01;
      end
    end
  end

  // Decoded settings for the video path and level generators
  always_comb
  begin
    cfg_next                     = '0;
    cfg_next.first_data_dly      = ths;
    cfg_next.gate_dly_lines      = tvs;
    cfg_next.source_drive_mode   = mem[3][5:4];
    cfg_next.pal_active          = mem[3][3] & is_yuv;
    cfg_next.pal_288_lines       = mem[3][2];
    cfg_next.luma_average        = mem[3][0] & is_yuv;
    cfg_next.contrast_x8         = mem[4][4:0];
    cfg_next.brightness_ofs      = {mem[5][6:0], 1'b0} - `PTC_BRI_ZERO;
    cfg_next.hue_deg             = is_yuv ? 7'(mem[6][7:4] * `PTC_HUE_STEP) - `PTC_HUE_ZERO
                                          : 7'h00;
    cfg_next.saturation_x8       = is_yuv ? mem[6][3:0] : `PTC_CON_UNITY;
    cfg_next.red_contrast_x8     = `PTC_SCON_BASE + {2'b00, mem[7][3:2]};
    cfg_next.blue_contrast_x8    = `PTC_SCON_BASE + {2'b00, mem[7][7:6]};
    cfg_next.red_brightness_ofs  = mem[8][5:0] - `PTC_SBRI_ZERO;
    cfg_next.blue_brightness_ofs = mem[9][5:0] - `PTC_SBRI_ZERO;
    cfg_next.common_dc_code      = mem[10][6] ? mem[10][5:0] : otp_dc_code_i;
    cfg_next.common_dc_mv        = `PTC_DC_BASE_MV
                                   + 12'(cfg_next.common_dc_code * `PTC_DC_STEP_MV);
    // Codes still reported under the switch, flagged unusable
    cfg_next.levels_valid        = !voltage_switch_bit_i;
    cfg_next.common_ac_x100mv    = `PTC_AC_BASE + {2'b00, mem[11][3:0]};
    cfg_next.gate_high_v         = `PTC_VGH_BASE + {2'b00, mem[11][5], ^mem[11][5:4]};
    cfg_next.gate_low_neg_v      = `PTC_VGL_BASE + {2'b00, mem[11][7], ^mem[11][7:6]};
    cfg_next.gamma_active        = mem[12][4] & !gamma_source_select_i;
    cfg_next.gamma_ofs_mv[0]     = `PTC_GAM_TOP_MV - 8'(mem[12][2:0] * `PTC_GAM_STEP_MV);
    cfg_next.gamma_ofs_mv[1]     = `PTC_GAM_TOP_MV - 8'(mem[13][2:0] * `PTC_GAM_STEP_MV);
    cfg_next.gamma_ofs_mv[2]     = `PTC_GAM_TOP_MV - 8'(mem[13][5:3] * `PTC_GAM_STEP_MV);
    cfg_next.gamma_ofs_mv[3]     = `PTC_GAM_TOP_MV - 8'(mem[14][2:0] * `PTC_GAM_STEP_MV);
    cfg_next.gamma_ofs_mv[4]     = `PTC_GAM_TOP_MV - 8'(mem[14][5:3] * `PTC_GAM_STEP_MV);
    if (!cfg_next.gamma_active)
      cfg_next.gamma_ofs_mv      = '0;
    cfg_next.display_width_mode  = is_yuv ? mem[15][1:0] : 2'b00;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cfg_o <= '0;
    else
      cfg_o <= cfg_next;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  property p_soft_reset;
    wr_en_reg && wr_addr_reg == `PTC_ADDR_SYS && !wr_data_reg[0]
      |=> ##1 (mem[4] == `PTC_RST_08 && mem[5] == `PTC_RST_09);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset lost");

  property p_glitch;
    $rose(filt_rst_reg) |-> $past(!rst_sync_reg[1]) && $past(rst_cnt_reg) == 16'(RST_FILT_CYC);
  endproperty
  a_glitch: assert property (p_glitch) else $error("reset without held pin");

  property p_first_data;
    first_data_o |-> $past(px_cnt_reg) == $past(ths) && !px_run_reg;
  endproperty
  a_first_data: assert property (p_first_data) else $error("first data mistimed");

  property p_reload;
    !clr && input_format_i != sel_prev_reg && !wr_en_reg
      |=> mem[0] == def_data_delay_code_f($past(input_format_i));
  endproperty
  a_reload: assert property (p_reload) else $error("format reload missing");

  property p_de_default;
    is_de && !pin_control_bit_i
      |=> cfg_o.first_data_dly == 9'(def_data_delay_code_f($past(input_format_i)));
  endproperty
  a_de_default: assert property (p_de_default) else $error("DE default ignored");

  property p_gate;
    gate_start_o |-> $past(ln_cnt_reg) == $past(tvs) && $past(hs_fall);
  endproperty
  a_gate: assert property (p_gate) else $error("gate start mistimed");

  property p_dc_src;
    ##1 cfg_o.common_dc_code == ($past(mem[10][6]) ? $past(mem[10][5:0])
                                                    : $past(otp_dc_code_i));
  endproperty
  a_dc_src: assert property (p_dc_src) else $error("dc code source wrong");

  property p_reserved;
    mem[2] == 8'h00 && mem[4][7:5] == 3'h0 && mem[15][7:2] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_gamma;
    ##1 !cfg_o.gamma_active |-> cfg_o.gamma_ofs_mv == '0;
  endproperty
  a_gamma: assert property (p_gamma) else $error("gamma offsets while off");

  property p_rd_turn;
    sda_oe_o |-> rd_reg && !spen_n;
  endproperty
  a_rd_turn: assert property (p_rd_turn) else $error("drive outside read");

  c_write:     cover property (wr_en_reg && mapped_f(wr_addr_reg));
  c_read:      cover property (sda_oe_o ##1 spck_fall);
  c_gate:      cover property (gate_start_o && adv);
  c_soft_rst:  cover property (soft_rst_reg);
endmodule
`default_nettype wire

// file: ptc_host_model.sv
// Host model driving the three-wire serial command link
`timescale 1ns/1ps
`default_nettype none
module ptc_host_model (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      spen_n_o,
  output logic      spck_o,
  output logic      sda_o
);
  initial
  begin
    spen_n_o = 1'b1;
    spck_o   = 1'b0;
    sda_o    = 1'b0;
  end
  // One frame: 16 bits MSB first, clock idles low between frames
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd,
                      output logic [7:0] q);
    logic [15:0] w;
    w = {a, rd, 1'b0, wd};
    q = 8'h00;
    @(posedge mclk_i);
    spen_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge mclk_i);
      spck_o <= 1'b0;
      // Released line toggles so a stale value cannot pass
      sda_o  <= (rd && i < 8) ? ~sda_o : w[i];
      repeat (6) @(posedge mclk_i);
      spck_o <= 1'b1;
      if (rd && i < 8)
        q[i] = sda_i;
      repeat (6) @(posedge mclk_i);
    end
    spck_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    spen_n_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the panel timing configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "ptc_params.svh"
module tb_top;
  import ptc_pkg::*;
  logic mclk = 0, arst_n = 0, rst_pin_n = 1, pin_ctl = 1, gsrc = 0, vsw = 0;
  logic [3:0] fmt = 4'h0;
  logic [5:0] otp = 6'h00;
  logic sda_o, sda_oe, first_data, gate_start, core_rst, core_q, spen_n, spck, hsda;
  ptc_video_t vid = '{pclk: 1'b0, hsync_n: 1'b1, vsync_n: 1'b1};
  ptc_serial_t ser;
  ptc_cfg_t cfg;
  int mismatches = 0, n_compared = 0, cycles = 0, n_rst = 0, n, r0;
  logic [7:0] d, q;
  logic [5:0] addrs [17] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B,
    6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h20, 6'h15};
  assign ser = '{spen_n: spen_n, spck: spck, sda: sda_oe ? sda_o : hsda};
  always #2.5 mclk = ~mclk;
  ptc_regs #(.RST_FILT_CYC(4)) ptc_regs_inst (.mclk_i(mclk), .arst_n_i(arst_n),
    .reset_input_n_i(rst_pin_n), .ser_i(ser), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .vid_i(vid), .input_format_i(fmt), .pin_control_bit_i(pin_ctl),
    .gamma_source_select_i(gsrc), .voltage_switch_bit_i(vsw), .otp_dc_code_i(otp),
    .first_data_o(first_data), .gate_start_o(gate_start), .core_rst_o(core_rst),
    .cfg_o(cfg));
  ptc_host_model ptc_host_model_inst (.mclk_i(mclk), .sda_i(ser.sda),
    .spen_n_o(spen_n), .spck_o(spck), .sda_o(hsda));
  always @(posedge mclk)
  begin
    core_q <= core_rst;
    n_rst <= n_rst + int'(core_rst && !core_q);
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      mismatches++;
      summarize();
    end
  end
  // Mask of implemented bits and reset value per address
  function automatic logic [15:0] tbl(input logic [5:0] a);
    case (a)
      6'h04: tbl = {8'hFF, `PTC_RST_04};
      6'h05: tbl = {8'h7F, `PTC_RST_05};
      6'h07: tbl = {8'hFD, `PTC_RST_07};
      6'h08: tbl = {8'h1F, `PTC_RST_08};
      6'h09: tbl = {8'h7F, `PTC_RST_09};
      6'h0A: tbl = {8'hFF, `PTC_RST_0A};
      6'h0B: tbl = {8'hCC, `PTC_RST_0B};
      6'h0C: tbl = {8'h3F, `PTC_RST_0C};
      6'h0D: tbl = {8'h3F, `PTC_RST_0D};
      6'h0E: tbl = {8'h7F, `PTC_RST_0E};
      6'h0F: tbl = {8'hFF, `PTC_RST_0F};
      6'h10: tbl = {8'h17, `PTC_RST_10};
      6'h11: tbl = {8'h3F, `PTC_RST_11};
      6'h12: tbl = {8'h3F, `PTC_RST_12};
      6'h20: tbl = {8'h03, `PTC_RST_20};
      default: tbl = 16'h0000;
    endcase
  endfunction
  // Gray-ordered level codes: 00, 01, 11, 10 step one volt each
  function automatic int lvl(input logic [1:0] c, input int base);
    lvl = base + (c == 2'b00 ? 0 : c == 2'b01 ? 1 : c == 2'b11 ? 2 : 3);
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] z;
    ptc_host_model_inst.xfer(1'b0, a, v, z);
    repeat (4) @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] z;
    ptc_host_model_inst.xfer(1'b1, a, 8'h00, z);
    chk({4'h0, z}, {4'h0, exp}, "readback");
  endtask
  // Count pixel clock rises from line sync to the first data pulse
  task automatic line(output int cnt);
    cnt = 0;
    vid.hsync_n <= 1'b0;
    repeat (4) @(posedge mclk);
    vid.hsync_n <= 1'b1;
    for (int k = 0; k < 4000 && !first_data; k++)
    begin
      vid.pclk <= (k % 8) < 4;
      cnt += int'(k % 8 == 0);
      @(posedge mclk);
    end
    vid.pclk <= 1'b0;
  endtask
  // Count line syncs from frame sync to the gate start pulse
  task automatic frame(output int cnt);
    cnt = 0;
    vid.vsync_n <= 1'b0;
    repeat (4) @(posedge mclk);
    vid.vsync_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 2000 && !gate_start; k++)
    begin
      vid.hsync_n <= (k % 8) >= 4;
      cnt += int'(k % 8 == 0);
      @(posedge mclk);
    end
    vid.hsync_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    r0 = $urandom(32'h5204);
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(6'h00, `PTC_SYS_RD);
    foreach (addrs[i])
      rd(addrs[i], tbl(addrs[i])[7:0]);
    foreach (addrs[i])
    begin
      d = 8'($urandom);
      wr(addrs[i], d);
      rd(addrs[i], d & tbl(addrs[i])[15:8]);
    end
    repeat (6)
    begin
      d = 8'($urandom);
      gsrc <= 1'($urandom);
      vsw <= 1'($urandom);
      otp <= 6'($urandom);
      wr(6'h08, d); wr(6'h09, d); wr(6'h0A, d); wr(6'h0B, d); wr(6'h0C, d);
      wr(6'h0E, d); wr(6'h10, d); wr(6'h20, d);
      wr(6'h07, d); wr(6'h0D, d); wr(6'h0F, d);
      chk(12'(cfg.source_drive_mode), 12'(d[5:4]), "inv");
      chk(12'(cfg.pal_active), 12'(d[3]), "pal");
      chk(12'(cfg.pal_288_lines), 12'(d[2]), "pal_line_count_bit");
      chk(12'(cfg.luma_average), 12'(d[0]), "avg");
      chk(12'(cfg.blue_brightness_ofs), 12'(6'(d[5:0] - 32)), "bbri");
      chk(12'(cfg.common_ac_x100mv), 12'(46 + d[3:0]), "ac");
      chk(12'(cfg.gate_high_v), 12'(lvl(d[5:4], 12)), "vgh");
      chk(12'(cfg.gate_low_neg_v), 12'(lvl(d[7:6], 7)), "vgl");
      chk(12'(cfg.contrast_x8), 12'(d[4:0]), "contrast");
      chk(12'(cfg.brightness_ofs), 12'(8'({d[6:0], 1'b0} - 8'h80)), "bright");
      chk(12'(cfg.hue_deg), 12'(7'(d[7:4] * 5 - 40)), "hue");
      chk(12'(cfg.saturation_x8), 12'(d[3:0]), "sat");
      chk(12'(cfg.red_contrast_x8), 12'(d[3:2] + 6), "rcon");
      chk(12'(cfg.blue_contrast_x8), 12'(d[7:6] + 6), "bcon");
      chk(12'(cfg.red_brightness_ofs), 12'(6'(d[5:0] - 32)), "rbri");
      q = {2'b00, d[6] ? d[5:0] : otp};
      chk(12'(cfg.common_dc_code), 12'(q), "dc");
      chk(cfg.common_dc_mv, 12'(1000 + 20 * q), "dcmv");
      chk(12'(cfg.levels_valid), 12'(!vsw), "vsw");
      chk(12'(cfg.gamma_active), 12'(d[4] && !gsrc), "gam");
      if (d[4] && !gsrc)
        chk(12'(cfg.gamma_ofs_mv[0]), 12'(8'(88 - 22 * d[2:0])), "tap");
      chk(12'(cfg.display_width_mode), 12'(d[1:0]), "wide");
    end
    fmt <= 4'h4;
    repeat (4) @(posedge mclk);
    rd(6'h04, `PTC_DATA_DELAY_CODE_DEF_656);
    rd(6'h05, `PTC_GATE_DELAY_CODE_DEF_656);
    fmt <= 4'h9;
    repeat (4) @(posedge mclk);
    wr(6'h04, 8'h11);
    pin_ctl <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(12'(cfg.first_data_dly), 12'(`PTC_DATA_DELAY_CODE_DEF_RGB), "de");
    pin_ctl <= 1'b1;
    foreach (addrs[i])
      if (i < 3)
      begin
        fmt <= 4'(i * 4);
        repeat (4) @(posedge mclk);
        d = 8'($urandom);
        wr(6'h04, d);
        line(n);
        chk(12'(n), 12'(d) + (i == 0 ? 12'd128 : i == 1 ? 12'd136 : 12'd0), "ths");
      end
    fmt <= 4'h8;
    repeat (4) @(posedge mclk);
    wr(6'h05, 8'h03);
    frame(n);
    chk(12'(n), 12'd4, "tvs");
    fmt <= 4'h0;
    repeat (4) @(posedge mclk);
    wr(6'h05, 8'h03);
    wr(6'h07, 8'h40);
    frame(n);
    chk(12'(n), 12'd5, "even late");
    frame(n);
    chk(12'(n), 12'd4, "odd same");
    r0 = n_rst;
    rst_pin_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(12'(n_rst - r0), 12'd0, "glitch");
    rst_pin_n <= 1'b0;
    repeat (12) @(posedge mclk);
    chk(12'(core_rst), 12'd1, "pinrst");
    rst_pin_n <= 1'b1;
    repeat (10) @(posedge mclk);
    rd(6'h08, `PTC_RST_08);
    wr(6'h08, 8'h1F);
    r0 = n_rst;
    wr(6'h00, 8'h00);
    chk(12'(n_rst - r0), 12'd1, "soft");
    rd(6'h08, `PTC_RST_08);
    rd(6'h00, `PTC_SYS_RD);
    summarize();
  end
endmodule
`default_nettype wire
